// [rtl/ums_master.sv]
// Master SPI transfer engine built from the transceiver's shared resources.
`timescale 1ns/100ps
module ums_master
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] operating_mode_select_field,
	input  wire logic       transmitter_enable_bit,
	input  wire logic       receiver_enable_bit,
	input  wire logic       clock_phase_bit,
	input  wire logic       clock_polarity_bit,
	input  wire logic       bit_order_select,
	input  wire logic       serial_clock_pin_direction,
	input  wire logic       baud_divisor_write,
	input  wire logic [11:0] baud_divisor_value,
	output logic [11:0]     baud_divisor,
	output logic            master_spi_mode,
	input  wire logic       tx_write_valid,
	input  wire logic [7:0] tx_write_data,
	output logic            tx_write_ready,
	output logic            rx_read_valid,
	output logic [7:0]      rx_read_data,
	input  wire logic       rx_read_ready,
	output logic            transmit_complete_flag,
	input  wire logic       transmit_complete_clear,
	output logic            receive_complete_flag,
	output logic            frame_error_flag,
	output logic            data_overrun_flag,
	output logic            parity_error_flag,
	output logic            serial_clock_pin_o,
	output logic            serial_clock_pin_oe,
	output logic            serial_data_out_pin,
	output logic            serial_data_out_oe,
	input  wire logic       serial_data_in_pin
);
	ums_pkg::ums_state_e state_reg;
	ums_pkg::ums_state_e state_next;
	logic [11:0] baud_reg;
	logic [11:0] tick_cnt_reg;
	logic [3:0]  edge_reg;
	logic        sck_reg;
	logic        mosi_reg;
	logic [7:0]  tx_sr_reg;
	logic [7:0]  rx_sr_reg;
	logic [7:0]  txbuf_reg;
	logic        txbuf_full_reg;
	logic        txc_reg;
	logic        miso_meta_reg;
	logic        miso_sync_reg;
	wire         engine_on;
	wire         rx_on;
	wire         tick;
	wire         leading;
	wire         trailing;
	wire         last_edge;
	wire         frame_done;
	wire         start;
	wire         load_next;
	wire         sample_ev;
	wire         setup_ev;
	wire         out_bit;
	wire [7:0]   tx_shifted;
	wire [7:0]   rx_shifted;
	wire [7:0]   load_byte;
	wire         tx_accept;
	wire         rxq_ready;
	wire         rxq_push;

	// The engine runs only in this mode with the transmitter on; the
	// separate asynchronous receive and transmit control is not built.
	assign master_spi_mode = (operating_mode_select_field ==
		ums_pkg::MODE_MSPI);
	assign engine_on = master_spi_mode & transmitter_enable_bit;
	assign rx_on     = engine_on & receiver_enable_bit;

	// No recovery logic exists, so these status flags are constant.
	assign frame_error_flag  = 1'b0;
	assign data_overrun_flag = 1'b0;
	assign parity_error_flag = 1'b0;

	// The divisor is held in a register that comes up at zero.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			baud_reg <= ums_pkg::DIV_RESET;
		end
		else if (baud_divisor_write)
		begin
			baud_reg <= baud_divisor_value;
		end
	end
	assign baud_divisor = baud_reg;

	// One tick every divisor plus one cycles gives a half serial period,
	// so a divisor of zero toggles the clock every system cycle.
	assign tick = engine_on && (state_reg == ums_pkg::UMS_SHIFT) &&
		(tick_cnt_reg == baud_reg);
	always_ff @(posedge clk)
	begin
		if (rst || !engine_on || tick || state_reg == ums_pkg::UMS_IDLE)
		begin
			tick_cnt_reg <= ums_pkg::DIV_RESET;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 12'h001;
		end
	end

	// Even edge counts are leading edges, odd counts trailing ones.
	assign leading   = tick & ~edge_reg[0];
	assign trailing  = tick & edge_reg[0];
	assign last_edge = (edge_reg == ums_pkg::EDGE_LAST);
	assign frame_done = tick & last_edge;

	// Phase 0 samples on leading edges and sets up on trailing ones;
	// phase 1 swaps them. The final trailing edge drives no new bit.
	assign sample_ev = clock_phase_bit ? trailing : leading;
	assign setup_ev  = clock_phase_bit ? leading :
		(trailing & ~last_edge);

	// The order bit picks the end both shift registers work from.
	assign out_bit    = bit_order_select ? tx_sr_reg[0] :
		tx_sr_reg[7];
	assign tx_shifted = bit_order_select ? {1'b0, tx_sr_reg[7:1]} :
		{tx_sr_reg[6:0], 1'b0};
	assign rx_shifted = bit_order_select ?
		{miso_sync_reg, rx_sr_reg[7:1]} :
		{rx_sr_reg[6:0], miso_sync_reg};

	// A queued byte starts a frame from idle or right after the last one.
	assign start     = (state_reg == ums_pkg::UMS_IDLE) & engine_on &
		txbuf_full_reg;
	assign load_next = frame_done & txbuf_full_reg;
	assign load_byte = txbuf_reg;

	// Transfer state: shifting while frames keep coming, idle otherwise.
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ums_pkg::UMS_IDLE:
			begin
				if (start)
				begin
					state_next = ums_pkg::UMS_SHIFT;
				end
			end
			ums_pkg::UMS_SHIFT:
			begin
				if (!engine_on || (frame_done && !txbuf_full_reg))
				begin
					state_next = ums_pkg::UMS_IDLE;
				end
			end
		endcase
	end

	// State and edge count; disabling the transmitter aborts a frame.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= ums_pkg::UMS_IDLE;
			edge_reg  <= ums_pkg::EDGE_FIRST;
		end
		else
		begin
			state_reg <= state_next;
			if (start || !engine_on)
			begin
				edge_reg <= ums_pkg::EDGE_FIRST;
			end
			else if (tick)
			begin
				edge_reg <= edge_reg + 4'h1;
			end
		end
	end

	// The base clock idles low and is flipped by the polarity bit.
	always_ff @(posedge clk)
	begin
		if (rst || !engine_on)
		begin
			sck_reg <= 1'b0;
		end
		else if (tick)
		begin
			sck_reg <= ~sck_reg;
		end
	end
	assign serial_clock_pin_o  = sck_reg ^ clock_polarity_bit;
	// The device only drives the clock when software made it an output.
	assign serial_clock_pin_oe = serial_clock_pin_direction;

	// Holding buffer in front of the shift register; a write is taken
	// while the previous byte is still shifting.
	assign tx_write_ready = engine_on & ~txbuf_full_reg;
	assign tx_accept      = tx_write_valid & tx_write_ready;
	always_ff @(posedge clk)
	begin
		if (rst || !engine_on)
		begin
			txbuf_full_reg <= 1'b0;
			txbuf_reg      <= ums_pkg::BYTE_ZERO;
		end
		else if (tx_accept)
		begin
			txbuf_full_reg <= 1'b1;
			txbuf_reg      <= tx_write_data;
		end
		else if (start || load_next)
		begin
			txbuf_full_reg <= 1'b0;
		end
	end

	// Phase 0 puts the first bit out at load, before any edge; phase 1
	// waits for the first leading edge. Idle line is held high.
	always_ff @(posedge clk)
	begin
		if (rst || !engine_on)
		begin
			tx_sr_reg <= ums_pkg::BYTE_ZERO;
			mosi_reg  <= ums_pkg::LINE_IDLE;
		end
		else if (start || load_next)
		begin
			if (clock_phase_bit)
			begin
				tx_sr_reg <= load_byte;
			end
			else if (bit_order_select)
			begin
				tx_sr_reg <= {1'b0, load_byte[7:1]};
				mosi_reg  <= load_byte[0];
			end
			else
			begin
				tx_sr_reg <= {load_byte[6:0], 1'b0};
				mosi_reg  <= load_byte[7];
			end
		end
		else if (frame_done)
		begin
			mosi_reg <= ums_pkg::LINE_IDLE;
		end
		else if (setup_ev)
		begin
			mosi_reg  <= out_bit;
			tx_sr_reg <= tx_shifted;
		end
	end
	assign serial_data_out_pin = mosi_reg;
	assign serial_data_out_oe  = engine_on;

	// The input pin is from outside the clock domain: two flops first.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			miso_meta_reg <= 1'b0;
			miso_sync_reg <= 1'b0;
		end
		else
		begin
			miso_meta_reg <= serial_data_in_pin;
			miso_sync_reg <= miso_meta_reg;
		end
	end

	// Receive shift register; a frame started from idle begins from a clean value.
	always_ff @(posedge clk)
	begin
		if (rst || start)
		begin
			rx_sr_reg <= ums_pkg::BYTE_ZERO;
		end
		else if (sample_ev)
		begin
			rx_sr_reg <= rx_shifted;
		end
	end

	// In phase 1 the last sample lands on the last edge, so the pushed byte takes
	// the fresh bit directly for phase 1 and the register for phase 0.
	assign rxq_push = frame_done & rx_on;

	// Transmit complete: set when the last frame ends with nothing queued,
	// cleared by writing one; a set in the clear cycle wins.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			txc_reg <= 1'b0;
		end
		else if (frame_done && !txbuf_full_reg)
		begin
			txc_reg <= 1'b1;
		end
		else if (transmit_complete_clear)
		begin
			txc_reg <= 1'b0;
		end
	end
	assign transmit_complete_flag = txc_reg;

	// A full buffer refuses the newest byte, which is then lost; the
	// trade-off keeps older unread bytes intact.
	ums_rx_fifo u_rx_fifo
	(
		.clk       (clk),
		.rst       (rst),
		.flush     (~rx_on),
		.in_valid  (rxq_push),
		.in_data   (clock_phase_bit ? rx_shifted : rx_sr_reg),
		.in_ready  (rxq_ready),
		.out_valid (rx_read_valid),
		.out_data  (rx_read_data),
		.out_ready (rx_read_ready)
	);

	// Receive complete mirrors the buffer holding unread data.
	assign receive_complete_flag = rx_read_valid;
endmodule

// [rtl/ums_pkg.sv]
// Shared constants for the master-only SPI mode of the serial transceiver.
package ums_pkg;
	localparam int             FRAME_BITS  = 8;
	localparam int             DIV_W       = 12;
	localparam logic [1:0]     MODE_MSPI   = 2'h3;
	localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
	localparam logic [3:0]     EDGE_FIRST  = 4'h0;
	localparam logic [3:0]     EDGE_LAST   = 4'hf;
	localparam logic [7:0]     BYTE_ZERO   = 8'h00;
	localparam logic           LINE_IDLE   = 1'b1;
	localparam int             RXQ_DEPTH   = 2;
	localparam logic [1:0]     RXQ_EMPTY   = 2'h0;
	localparam logic [1:0]     RXQ_ONE     = 2'h1;
	localparam logic [1:0]     RXQ_FULL    = 2'h2;

	typedef enum logic [0:0]
	{
		UMS_IDLE  = 1'b0,
		UMS_SHIFT = 1'b1
	} ums_state_e;
endpackage

// [rtl/ums_rx_fifo.sv]
// Two-entry receive buffer with valid and ready on both sides.
`timescale 1ns/100ps
module ums_rx_fifo
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       flush,
	input  wire logic       in_valid,
	input  wire logic [7:0] in_data,
	output logic            in_ready,
	output logic            out_valid,
	output logic [7:0]      out_data,
	input  wire logic       out_ready
);
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic [7:0] slot_reg [ums_pkg::RXQ_DEPTH];
	logic [7:0] slot_next [ums_pkg::RXQ_DEPTH];
	wire        push;
	wire        pop;

	// Full means the newest byte is refused; older entries stay put.
	assign in_ready  = (count_reg != ums_pkg::RXQ_FULL);
	assign out_valid = (count_reg != ums_pkg::RXQ_EMPTY);
	assign out_data  = slot_reg[0];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Slot 0 is always the oldest byte, so a pop shifts slot 1 down.
	always_comb
	begin
		count_next   = count_reg;
		slot_next[0] = slot_reg[0];
		slot_next[1] = slot_reg[1];
		if (pop)
		begin
			slot_next[0] = slot_reg[1];
		end
		if (push)
		begin
			if (count_reg == ums_pkg::RXQ_EMPTY ||
				(count_reg == ums_pkg::RXQ_ONE && pop))
			begin
				slot_next[0] = in_data;
			end
			else
			begin
				slot_next[1] = in_data;
			end
		end
		count_next = count_reg + {1'b0, push} - {1'b0, pop};
	end

	// Flushing empties the buffer when the receiver is switched off.
	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			count_reg   <= ums_pkg::RXQ_EMPTY;
			slot_reg[0] <= ums_pkg::BYTE_ZERO;
			slot_reg[1] <= ums_pkg::BYTE_ZERO;
		end
		else
		begin
			count_reg   <= count_next;
			slot_reg[0] <= slot_next[0];
			slot_reg[1] <= slot_next[1];
		end
	end
endmodule

// [tb/tb.sv]
// Self-checking bench for the master SPI transfer engine.
`timescale 1ns/100ps
module tb;
	logic	clk = 1'b0, rst = 1'b1;
	logic [1:0]	operating_mode_select_field = 2'h3;
	logic	transmitter_enable_bit = 1'b0, receiver_enable_bit = 1'b0;
	logic	clock_phase_bit = 1'b0, clock_polarity_bit = 1'b0;
	logic	bit_order_select = 1'b0, serial_clock_pin_direction = 1'b0;
	logic	baud_divisor_write = 1'b0, tx_write_valid = 1'b0;
	logic [11:0]	baud_divisor_value = 12'h000;
	logic [7:0]	tx_write_data = 8'h00;
	logic	rx_read_ready = 1'b0, transmit_complete_clear = 1'b0;
	logic [11:0]	baud_divisor;
	logic [7:0]	rx_read_data;
	logic	master_spi_mode, tx_write_ready, rx_read_valid;
	logic	transmit_complete_flag, receive_complete_flag;
	logic	frame_error_flag, data_overrun_flag, parity_error_flag;
	logic	serial_clock_pin_o, serial_clock_pin_oe;
	logic	serial_data_out_pin, serial_data_out_oe;
	wire logic	serial_data_in_pin;
	logic [15:0]	slv_din = 16'h0000, slv_dout;
	logic	slv_start = 1'b0;
	logic [7:0]	wb [3];
	logic [7:0]	exp_q [$];
	int	miscompares = 0, cmp_count = 0;

	always #4 clk = ~clk;

	ums_master i_ums_master (.clk, .rst, .operating_mode_select_field,
		.transmitter_enable_bit, .receiver_enable_bit, .clock_phase_bit,
		.clock_polarity_bit, .bit_order_select, .serial_clock_pin_direction,
		.baud_divisor_write, .baud_divisor_value, .baud_divisor,
		.master_spi_mode, .tx_write_valid, .tx_write_data, .tx_write_ready,
		.rx_read_valid, .rx_read_data, .rx_read_ready, .transmit_complete_flag,
		.transmit_complete_clear, .receive_complete_flag, .frame_error_flag,
		.data_overrun_flag, .parity_error_flag, .serial_clock_pin_o,
		.serial_clock_pin_oe, .serial_data_out_pin, .serial_data_out_oe,
		.serial_data_in_pin);
	ums_slave_model i_ums_slave_model (.sck(serial_clock_pin_o),
		.mosi(serial_data_out_pin), .pol(clock_polarity_bit),
		.pha(clock_phase_bit), .lsb(bit_order_select), .start(slv_start),
		.din(slv_din), .miso(serial_data_in_pin), .dout(slv_dout));

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t ns: seen %h, expected %h", $time, s, e);
		end
	endtask

	task automatic complete_run();
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hold the byte until the buffer is seen free, then drop valid.
	task automatic wr(input logic [7:0] d);
		@(negedge clk);
		tx_write_valid = 1'b1;
		tx_write_data = d;
		while (!tx_write_ready) @(negedge clk);
		@(negedge clk);
		tx_write_valid = 1'b0;
	endtask

	// One to three queued bytes; the model predicts edges, span and data.
	task automatic xfer(input int i);
		int	n, d, e, t, t0, t1;
		logic	p;
		n = 1 + i % 3;
		d = 2 + $urandom % 4;
		for (int b = 0; b < 3; b++) wb[b] = 8'($urandom);
		@(negedge clk);
		{clock_phase_bit, clock_polarity_bit} = i[1:0];
		bit_order_select = 1'($urandom);
		receiver_enable_bit = (i % 5 != 4);
		slv_din = 16'($urandom);
		baud_divisor_write = 1'b1;
		baud_divisor_value = d[11:0];
		transmit_complete_clear = 1'b1;
		@(negedge clk);
		baud_divisor_write = 1'b0;
		transmit_complete_clear = 1'b0;
		slv_start = 1'b1;
		@(negedge clk);
		slv_start = 1'b0;
		chk(baud_divisor, d);
		chk(transmit_complete_flag, 0);
		e = 0;
		t = 0;
		p = serial_clock_pin_o;
		fork
			for (int b = 0; b < n; b++) wr(wb[b]);
			while (!transmit_complete_flag && t < 20000)
			begin
				@(negedge clk);
				t++;
				if (serial_clock_pin_o !== p)
				begin
					if (e == 0) t0 = t;
					e++;
					t1 = t;
					p = serial_clock_pin_o;
				end
			end
		join
		chk(e, 16 * n);
		chk(t1 - t0, (16 * n - 1) * (d + 1));
		chk(serial_data_out_pin, 1);
		chk(serial_clock_pin_o, clock_polarity_bit);
		chk(slv_dout[15:8], wb[0]);
		if (n > 1) chk(slv_dout[7:0], wb[1]);
		exp_q = {};
		if (receiver_enable_bit) exp_q.push_back(slv_din[15:8]);
		if (receiver_enable_bit && n > 1) exp_q.push_back(slv_din[7:0]);
		while (exp_q.size() > 0)
		begin
			chk(rx_read_valid, 1);
			chk(rx_read_data, exp_q.pop_front());
			rx_read_ready = 1'b1;
			@(negedge clk);
			rx_read_ready = 1'b0;
			@(negedge clk);
		end
		chk(rx_read_valid, 0);
	endtask

	// Reset, mode decode, then transfers in every mode with a stalling reader.
	initial
	begin
		void'($urandom(94));
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk(baud_divisor, 0);
		chk(serial_data_out_pin, 1);
		chk(serial_clock_pin_o, clock_polarity_bit);
		// Setup is done before any enable, with nothing able to interrupt it.
		serial_clock_pin_direction = 1'b1;
		for (int m = 0; m < 8; m++)
		begin
			@(negedge clk);
			operating_mode_select_field = m[1:0];
			transmitter_enable_bit = m[2];
			@(negedge clk);
			chk(master_spi_mode, m[1:0] == 2'h3);
			chk(tx_write_ready, m == 7);
		end
		for (int i = 0; i < 12; i++) xfer(i);
		complete_run();
	end

	// The tests need about two thousand cycles; this cuts off a hang.
	initial
	begin
		#400000;
		miscompares++;
		complete_run();
	end
endmodule

// [tb/ums_master_monitor.sv]
// Port checker for the master SPI transfer engine, with its bind.
`timescale 1ns/100ps
module ums_master_monitor
(
	input wire logic	clk,
	input wire logic	rst,
	input wire logic [1:0]	operating_mode_select_field,
	input wire logic	transmitter_enable_bit,
	input wire logic	clock_polarity_bit,
	input wire logic	serial_clock_pin_direction,
	input wire logic	transmit_complete_clear,
	input wire logic [11:0]	baud_divisor,
	input wire logic	master_spi_mode,
	input wire logic	tx_write_valid,
	input wire logic	tx_write_ready,
	input wire logic	rx_read_valid,
	input wire logic	receive_complete_flag,
	input wire logic	transmit_complete_flag,
	input wire logic	frame_error_flag,
	input wire logic	data_overrun_flag,
	input wire logic	parity_error_flag,
	input wire logic	serial_clock_pin_o,
	input wire logic	serial_clock_pin_oe,
	input wire logic	serial_data_out_pin,
	input wire logic	serial_data_out_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// Cycles since the serial clock last moved; an int cannot wrap here.
	int	gap;
	always_ff @(posedge clk)
		gap <= (rst || $changed(serial_clock_pin_o)) ? 0 : gap + 1;

	// Static decodes and constant flags.
	chk_mode_decode: assert property (
		master_spi_mode == (operating_mode_select_field == 2'h3))
		else $error("mode decode");
	chk_flags_zero: assert property (
		!(frame_error_flag || data_overrun_flag || parity_error_flag))
		else $error("error flag");
	chk_out_enable: assert property (
		serial_data_out_oe == (master_spi_mode && transmitter_enable_bit))
		else $error("data oe");
	chk_clk_dir: assert property (
		serial_clock_pin_oe == serial_clock_pin_direction)
		else $error("clock oe");
	chk_rx_flag: assert property (
		receive_complete_flag == rx_read_valid)
		else $error("receive flag");
	// Handshake, flag and line timing.
	chk_tx_off: assert property (
		!transmitter_enable_bit |-> !tx_write_ready)
		else $error("ready while off");
	chk_ready_drop: assert property (
		tx_write_valid && tx_write_ready |=> !tx_write_ready)
		else $error("buffer still free");
	chk_txc_sticky: assert property (
		transmit_complete_flag && !transmit_complete_clear
		|=> transmit_complete_flag)
		else $error("complete flag lost");
	chk_end_idle: assert property (
		$rose(transmit_complete_flag) |-> serial_data_out_pin &&
		serial_clock_pin_o == clock_polarity_bit)
		else $error("lines not idle at end");
	chk_sck_spacing: assert property (
		$changed(serial_clock_pin_o) && $stable(clock_polarity_bit)
		|-> gap >= baud_divisor)
		else $error("serial clock too fast");

	cover property ($rose(transmit_complete_flag));
	cover property (tx_write_valid && tx_write_ready);
	cover property (rx_read_valid);
endmodule

bind ums_master ums_master_monitor i_ums_master_monitor
(
	.clk, .rst, .operating_mode_select_field, .transmitter_enable_bit,
	.clock_polarity_bit, .serial_clock_pin_direction,
	.transmit_complete_clear, .baud_divisor, .master_spi_mode,
	.tx_write_valid, .tx_write_ready, .rx_read_valid,
	.receive_complete_flag, .transmit_complete_flag, .frame_error_flag,
	.data_overrun_flag, .parity_error_flag, .serial_clock_pin_o,
	.serial_clock_pin_oe, .serial_data_out_pin, .serial_data_out_oe
);

// [tb/ums_slave_model.sv]
// Behavioural three-wire slave that answers two bytes per start pulse.
`timescale 1ns/100ps
module ums_slave_model
(
	input wire logic	sck,
	input wire logic	mosi,
	input wire logic	pol,
	input wire logic	pha,
	input wire logic	lsb,
	input wire logic	start,
	input wire logic [15:0]	din,
	output logic	miso,
	output logic [15:0]	dout
);
	wire	act = sck ^ pol;
	int	n;
	int	k;
	logic	mosi_now;
	logic	mosi_was;
	realtime	mosi_at = 0.0;

	// The master may move the data line in the very step of the last
	// sampling edge; a real slave still sees the level that stood before.
	always @(mosi)
	begin
		mosi_was = mosi_now;
		mosi_now = mosi;
		mosi_at  = $realtime;
	end

	// Bit b of the answer stream, in the selected order.
	function automatic logic bit_at(input int b);
		logic [7:0]	v;
		v = (b < 8) ? din[15:8] : din[7:0];
		return lsb ? v[b % 8] : v[7 - b % 8];
	endfunction

	// Past the answer the line is inverted, never left at its last value.
	task automatic setup_edge();
		n++;
		miso = (n < 16) ? bit_at(n) : ~miso;
	endtask

	task automatic sample_edge();
		if (k < 16)
			dout[(k < 8 ? 8 : 0) + (lsb ? k % 8 : 7 - k % 8)] =
				(mosi_at == $realtime) ? mosi_was : mosi_now;
		k++;
		if (k % 8 == 0)
			miso = ~miso;
	endtask

	// A start pulse wipes any edges seen while the settings moved.
	initial miso = 1'b0;
	always @(posedge start)
	begin
		n = pha ? -1 : 0;
		k = 0;
		dout = 16'h0000;
		miso = pha ? ~miso : bit_at(0);
	end
	always @(posedge act) if (pha) setup_edge(); else sample_edge();
	always @(negedge act) if (pha) sample_edge(); else setup_edge();
endmodule
